// File: shared/cfa_cfg.svh
/*
 Constants of the flag/ALU core: register offsets, field positions,
 reset values, vectors and instruction cycle counts.
 Assumes inclusion by bare name from the core and its bench.
*/
// Functional notes
// - Negative flag copies bit 7 of every accumulator add, and or shift result.
// - Zero flag set when the result is all zeros, else cleared.
// - Carry set on carry out of bit 7 in adds, else cleared.
// - Shifts also update carry from the bit shifted out.
// - Wait clears mask, gates clock; interrupt exit keeps mask clear.
// - Stop clears mask, gates clock; external interrupt exit keeps it.
// - After stop exit clock stays gated for the oscillator delay.
// - Break loads the interrupt opcode and the break or monitor vector.
// - Break waits for instruction end; on its last cycle, at once.
// - Return inside break ends it once the request has dropped.
// - Add with carry: A+M+C into A, V H N Z C updated, 2-5 cycles.
// - Plain add: A+M into A, same flags, modes and cycles.
// - And: A&M into A, V cleared, N Z updated, H C kept.
// - Stack pointer plus sign-extended immediate, 2 cycles, no flags.
// - Index pair plus sign-extended immediate, 2 cycles, no flags.
// - Shift left: bit 7 to carry, zero in, V N Z C updated.
// - Shift right decoded in six modes, V N Z C updated.
// - Carry-clear branch: own address plus 2 plus offset, 3 cycles.
// - Half carry set on carry from bit 3 into bit 4 in adds.
// - Overflow set on two's complement signed overflow.
`ifndef CFA_CFG_SVH
`define CFA_CFG_SVH
// Register offsets
`define CFA_OFF_ACC    4'h0
`define CFA_OFF_CND    4'h1
`define CFA_OFF_HX_HI  4'h2
`define CFA_OFF_HX_LO  4'h3
`define CFA_OFF_SP_HI  4'h4
`define CFA_OFF_SP_LO  4'h5
`define CFA_OFF_PC_HI  4'h6
`define CFA_OFF_PC_LO  4'h7
`define CFA_OFF_CTRL   4'h8
`define CFA_OFF_STAT   4'h9
// Condition code field positions
`define CFA_CND_V 7
`define CFA_CND_H 4
`define CFA_CND_I 3
`define CFA_CND_N 2
`define CFA_CND_Z 1
`define CFA_CND_C 0
`define CFA_CND_ONES   8'h60
// Control and status fields
`define CFA_CTRL_MON   0
`define CFA_STAT_ILL   0
`define CFA_STAT_BRK   1
`define CFA_STAT_RUN   2
`define CFA_STAT_BUSY  3
// Reset values and vectors
`define CFA_RST_SP     16'h00FF
`define CFA_RST_PC     16'hFFFE
`define CFA_VEC_BRK    16'hFFFC
`define CFA_VEC_MON    16'hFEFC
// Cycle counts of the operand modes
`define CFA_CY_IMM 3'h2
`define CFA_CY_DIR 3'h3
`define CFA_CY_EXT 3'h4
`define CFA_CY_IX2 3'h4
`define CFA_CY_IX1 3'h3
`define CFA_CY_IX  3'h2
`define CFA_CY_SP1 3'h4
`define CFA_CY_SP2 3'h5
`define CFA_SH_DIR 3'h4
`define CFA_SH_INH 3'h1
`define CFA_SH_IX1 3'h4
`define CFA_SH_IX  3'h3
`define CFA_SH_SP1 3'h5
`define CFA_CY_ADX 3'h2
`define CFA_CY_BRC 3'h3
`endif

// File: shared/cfa_pkg.sv
/*
 Types of the flag/ALU core: operations, targets, modes, carriers
 and the core state. Assumes nothing beyond a SystemVerilog compiler.
*/
package cfa_pkg;
   typedef enum logic [3:0] {
      K_NONE = 4'h0, K_ADC = 4'h1, K_ADD = 4'h2, K_AND = 4'h3,
      K_SHL = 4'h4, K_SHR = 4'h5, K_ADS = 4'h6, K_ADX = 4'h7,
      K_BRC = 4'h8
   } cfa_kind_e;
   typedef enum logic [1:0] {
      T_MEM = 2'h0, T_ACC = 2'h1, T_IDX = 2'h2
   } cfa_tgt_e;
   typedef enum logic [1:0] {
      M_RUN = 2'h0, M_WAIT = 2'h1, M_STOP = 2'h2, M_OSC = 2'h3
   } cfa_mode_e;
   typedef enum logic [1:0] {
      S_NONE = 2'h0, S_WAIT = 2'h1, S_STOP = 2'h2, S_RET = 2'h3
   } cfa_sys_e;
   typedef struct packed {
      cfa_kind_e  kind;
      cfa_tgt_e   tgt;
      logic [2:0] cyc;
      logic [2:0] len;
   } cfa_dec_s;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cfa_bus_s;
   typedef struct packed {
      logic        valid;
      logic [15:0] op;
      logic [7:0]  opnd;
   } cfa_instr_s;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cfa_mem_s;
   typedef struct packed {
      logic [7:0]  acc;
      logic [15:0] hx;
      logic [15:0] sp;
      logic [15:0] pc;
      logic        v, h, i, n, z, c;
      cfa_mode_e   mode;
      logic [2:0]  cnt;
      logic [15:0] dly;
      logic        brk, mon, ill;
      logic [7:0]  ir;
      logic [7:0]  rd;
      logic        rdy, clken;
      cfa_mem_s    mem;
      logic [2:0]  sync;
   } cfa_state_s;
endpackage

// File: rtl/cfa_core.sv
/*
 Flag/ALU execution core: condition flags, add, add with carry, and,
 signed immediate adds, shifts, carry-clear branch, wait and stop
 entry and exit, and break entry and exit, with a byte register port.
 Assumes operands are fetched outside and handed in with the opcode,
 and that the break and interrupt requests share the core clock.
*/
// The plain strobed port and the register addresses are this design's own decisions.
`include "cfa_cfg.svh"

module cfa_core #(
   parameter int unsigned OSC_DLY_CYC = 4096,
   parameter logic [7:0]  TRP_CODE    = 8'h00
) (
   // Clock and reset
   input  wire logic               mclk_i,
   input  wire logic               nrst_i,
   // Register port
   input  wire cfa_pkg::cfa_bus_s  bus_i,
   output logic [7:0]              rd_data_o,
   // Instruction issue
   input  wire cfa_pkg::cfa_instr_s instr_i,
   input  wire cfa_pkg::cfa_sys_e  sys_cmd_i,
   output logic                    ready_o,
   // Requests from break and interrupt logic
   input  wire logic               break_req_i,
   input  wire logic               irq_i,
   input  wire logic               ext_irq_i,
   // Core status and results
   output logic                    cpu_clk_en_o,
   output logic                    in_break_o,
   output logic [7:0]              ir_o,
   output logic [15:0]             pc_o,
   output cfa_pkg::cfa_mem_s       mem_o
);

   cfa_pkg::cfa_state_s q;
   cfa_pkg::cfa_state_s d;

   // Operand mode table of the three accumulator operations
   function automatic cfa_pkg::cfa_dec_s alu_mode(
      input logic [3:0] hi, input cfa_pkg::cfa_kind_e k);
      cfa_pkg::cfa_dec_s r;
      r = '{kind: k, tgt: cfa_pkg::T_ACC, cyc: `CFA_CY_IMM, len: 3'h2};
      case (hi)
         4'hB: r.cyc = `CFA_CY_DIR;
         4'hC:
         begin
            r.cyc = `CFA_CY_EXT;
            r.len = 3'h3;
         end
         4'hD:
         begin
            r.cyc = `CFA_CY_IX2;
            r.len = 3'h3;
         end
         4'hE: r.cyc = `CFA_CY_IX1;
         4'hF:
         begin
            r.cyc = `CFA_CY_IX;
            r.len = 3'h1;
         end
         default: r.cyc = `CFA_CY_IMM;
      endcase
      return r;
   endfunction

   // Opcode decode; unknown codes give K_NONE
   function automatic cfa_pkg::cfa_dec_s decode(input logic [15:0] op);
      cfa_pkg::cfa_dec_s r;
      cfa_pkg::cfa_kind_e k;
      r = '{kind: cfa_pkg::K_NONE, tgt: cfa_pkg::T_MEM, cyc: 3'h1,
            len: 3'h1};
      case (op[3:0])
         4'h9: k = cfa_pkg::K_ADC;
         4'hB: k = cfa_pkg::K_ADD;
         4'h4: k = cfa_pkg::K_AND;
         4'h8: k = cfa_pkg::K_SHL;
         4'h7: k = cfa_pkg::K_SHR;
         default: k = cfa_pkg::K_NONE;
      endcase
      if (op[15:8] == 8'h00)
      begin
         if (op[7:0] == 8'hA7)
            r = '{kind: cfa_pkg::K_ADS, tgt: cfa_pkg::T_MEM,
                  cyc: `CFA_CY_ADX, len: 3'h2};
         else if (op[7:0] == 8'hAF)
            r = '{kind: cfa_pkg::K_ADX, tgt: cfa_pkg::T_MEM,
                  cyc: `CFA_CY_ADX, len: 3'h2};
         else if (op[7:0] == 8'h24)
            r = '{kind: cfa_pkg::K_BRC, tgt: cfa_pkg::T_MEM,
                  cyc: `CFA_CY_BRC, len: 3'h2};
         else if ((k == cfa_pkg::K_ADC || k == cfa_pkg::K_ADD ||
                   k == cfa_pkg::K_AND) && op[7:4] >= 4'hA)
            r = alu_mode(op[7:4], k);
         else if ((k == cfa_pkg::K_SHL || k == cfa_pkg::K_SHR) &&
                  op[7:4] >= 4'h3 && op[7:4] <= 4'h7)
         begin
            r.kind = k;
            case (op[7:4])
               4'h3:
               begin
                  r.cyc = `CFA_SH_DIR;
                  r.len = 3'h2;
               end
               4'h4:
               begin
                  r.tgt = cfa_pkg::T_ACC;
                  r.cyc = `CFA_SH_INH;
               end
               4'h5:
               begin
                  r.tgt = cfa_pkg::T_IDX;
                  r.cyc = `CFA_SH_INH;
               end
               4'h6:
               begin
                  r.cyc = `CFA_SH_IX1;
                  r.len = 3'h2;
               end
               default: r.cyc = `CFA_SH_IX;
            endcase
         end
      end
      else if (op[15:8] == 8'h9E)
      begin
         if ((k == cfa_pkg::K_ADC || k == cfa_pkg::K_ADD ||
              k == cfa_pkg::K_AND) && (op[7:4] == 4'hE || op[7:4] == 4'hD))
         begin
            r = alu_mode(4'hA, k);
            r.cyc = (op[7:4] == 4'hE) ? `CFA_CY_SP1 : `CFA_CY_SP2;
            r.len = (op[7:4] == 4'hE) ? 3'h3 : 3'h4;
         end
         else if ((k == cfa_pkg::K_SHL || k == cfa_pkg::K_SHR) &&
                  op[7:4] == 4'h6)
            r = '{kind: k, tgt: cfa_pkg::T_MEM, cyc: `CFA_SH_SP1,
                  len: 3'h3};
      end
      return r;
   endfunction

   // Next state of the whole core
   always_comb
   begin
      cfa_pkg::cfa_dec_s dec;
      logic [7:0]  src;
      logic [7:0]  res;
      logic [8:0]  sum;
      logic        ext_hi;
      logic        brk_go;
      logic        idle;
      logic [15:0] sx;
      dec    = decode(instr_i.op);
      src    = 8'h00;
      res    = 8'h00;
      sum    = 9'h000;
      sx     = {{8{instr_i.opnd[7]}}, instr_i.opnd};
      d      = q;
      d.rd   = 8'h00;
      d.mem  = '0;
      // Pin synchroniser; level counts as high when stages two and three are both high
      d.sync = {q.sync[1:0], ext_irq_i};
      ext_hi = q.sync[1] & q.sync[2];
      idle   = (q.mode == cfa_pkg::M_RUN) && (q.cnt <= 3'h1);
      brk_go = idle && break_req_i && !q.brk;
      // Register writes
      if (bus_i.wr)
      begin
         case (bus_i.addr)
            `CFA_OFF_ACC:   d.acc = bus_i.wdata;
            `CFA_OFF_CND:
            begin
               d.v = bus_i.wdata[`CFA_CND_V];
               d.h = bus_i.wdata[`CFA_CND_H];
               d.i = bus_i.wdata[`CFA_CND_I];
               d.n = bus_i.wdata[`CFA_CND_N];
               d.z = bus_i.wdata[`CFA_CND_Z];
               d.c = bus_i.wdata[`CFA_CND_C];
            end
            `CFA_OFF_HX_HI: d.hx[15:8] = bus_i.wdata;
            `CFA_OFF_HX_LO: d.hx[7:0]  = bus_i.wdata;
            `CFA_OFF_SP_HI: d.sp[15:8] = bus_i.wdata;
            `CFA_OFF_SP_LO: d.sp[7:0]  = bus_i.wdata;
            `CFA_OFF_PC_HI: d.pc[15:8] = bus_i.wdata;
            `CFA_OFF_PC_LO: d.pc[7:0]  = bus_i.wdata;
            `CFA_OFF_CTRL:  d.mon = bus_i.wdata[`CFA_CTRL_MON];
            `CFA_OFF_STAT:
               if (bus_i.wdata[`CFA_STAT_ILL])
                  d.ill = 1'b0;
            default: d.ill = q.ill;
         endcase
      end
      // Register reads, data in the following cycle
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            `CFA_OFF_ACC:   d.rd = q.acc;
            `CFA_OFF_CND:   d.rd = {q.v, 2'b11, q.h, q.i, q.n, q.z, q.c};
            `CFA_OFF_HX_HI: d.rd = q.hx[15:8];
            `CFA_OFF_HX_LO: d.rd = q.hx[7:0];
            `CFA_OFF_SP_HI: d.rd = q.sp[15:8];
            `CFA_OFF_SP_LO: d.rd = q.sp[7:0];
            `CFA_OFF_PC_HI: d.rd = q.pc[15:8];
            `CFA_OFF_PC_LO: d.rd = q.pc[7:0];
            `CFA_OFF_CTRL:  d.rd = {7'h00, q.mon};
            `CFA_OFF_STAT:  d.rd = {4'h0, q.cnt != 3'h0,
                                    q.mode == cfa_pkg::M_RUN, q.brk, q.ill};
            default:        d.rd = 8'h00;
         endcase
      end
      // Execution and low-power sequencing
      case (q.mode)
         cfa_pkg::M_RUN:
         begin
            if (q.cnt != 3'h0)
               d.cnt = q.cnt - 3'h1;
            if (brk_go)
            begin
               d.ir  = TRP_CODE;
               d.pc  = q.mon ? `CFA_VEC_MON : `CFA_VEC_BRK;
               d.brk = 1'b1;
            end
            else if (q.cnt == 3'h0 && sys_cmd_i != cfa_pkg::S_NONE)
            begin
               case (sys_cmd_i)
                  cfa_pkg::S_WAIT:
                  begin
                     d.i    = 1'b0;
                     d.mode = cfa_pkg::M_WAIT;
                  end
                  cfa_pkg::S_STOP:
                  begin
                     d.i    = 1'b0;
                     d.mode = cfa_pkg::M_STOP;
                  end
                  default:
                     if (q.brk && !break_req_i)
                        d.brk = 1'b0;
               endcase
            end
            else if (q.cnt == 3'h0 && instr_i.valid)
            begin
               d.cnt = dec.cyc - 3'h1;
               d.ir  = instr_i.op[7:0];
               d.pc  = q.pc + {13'h0000, dec.len};
               case (dec.tgt)
                  cfa_pkg::T_ACC: src = q.acc;
                  cfa_pkg::T_IDX: src = q.hx[7:0];
                  default:        src = instr_i.opnd;
               endcase
               case (dec.kind)
                  cfa_pkg::K_ADC, cfa_pkg::K_ADD:
                  begin
                     sum = {1'b0, q.acc} + {1'b0, instr_i.opnd} +
                           {8'h00, dec.kind == cfa_pkg::K_ADC && q.c};
                     res = sum[7:0];
                     d.acc = res;
                     d.c = sum[8];
                     d.h = q.acc[4] ^ instr_i.opnd[4] ^ res[4];
                     d.v = (q.acc[7] == instr_i.opnd[7]) &&
                           (res[7] != q.acc[7]);
                  end
                  cfa_pkg::K_AND:
                  begin
                     res   = q.acc & instr_i.opnd;
                     d.acc = res;
                     d.v   = 1'b0;
                  end
                  cfa_pkg::K_SHL, cfa_pkg::K_SHR:
                  begin
                     if (dec.kind == cfa_pkg::K_SHL)
                     begin
                        res = {src[6:0], 1'b0};
                        d.c = src[7];
                     end
                     else
                     begin
                        res = {src[7], src[7:1]};
                        d.c = src[0];
                     end
                     d.v = res[7] ^ d.c;
                     case (dec.tgt)
                        cfa_pkg::T_ACC: d.acc = res;
                        cfa_pkg::T_IDX: d.hx[7:0] = res;
                        default:        d.mem = '{valid: 1'b1, data: res};
                     endcase
                  end
                  cfa_pkg::K_ADS: d.sp = q.sp + sx;
                  cfa_pkg::K_ADX: d.hx = q.hx + sx;
                  cfa_pkg::K_BRC:
                     if (!q.c)
                        d.pc = q.pc + 16'h0002 + sx;
                  default: d.ill = 1'b1;
               endcase
               // Result flags of the add, add with carry, and and shift operations
               if (dec.kind inside {cfa_pkg::K_ADC, cfa_pkg::K_ADD,
                                    cfa_pkg::K_AND, cfa_pkg::K_SHL,
                                    cfa_pkg::K_SHR})
               begin
                  d.n = res[7];
                  d.z = (res == 8'h00);
               end
            end
         end
         cfa_pkg::M_WAIT:
            if (irq_i)
               d.mode = cfa_pkg::M_RUN;
         cfa_pkg::M_STOP:
            if (ext_hi)
            begin
               d.mode = cfa_pkg::M_OSC;
               d.dly  = OSC_DLY_CYC[15:0];
            end
         cfa_pkg::M_OSC:
         begin
            d.dly = q.dly - 16'h0001;
            if (q.dly <= 16'h0001)
               d.mode = cfa_pkg::M_RUN;
         end
         default: d.mode = cfa_pkg::M_RUN;
      endcase
      // Registered handshake and clock gate
      d.clken = (d.mode == cfa_pkg::M_RUN);
      d.rdy   = (d.mode == cfa_pkg::M_RUN) && (d.cnt == 3'h0);
   end

   // State register; reset sets the mask and the reset pointers
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         q       <= '0;
         q.i     <= 1'b1;
         q.sp    <= `CFA_RST_SP;
         q.pc    <= `CFA_RST_PC;
         q.mode  <= cfa_pkg::M_RUN;
         q.rdy   <= 1'b1;
         q.clken <= 1'b1;
      end
      else
         q <= d;
   end

   // Outputs straight from the state register
   assign rd_data_o    = q.rd;
   assign ready_o      = q.rdy;
   assign cpu_clk_en_o = q.clken;
   assign in_break_o   = q.brk;
   assign ir_o         = q.ir;
   assign pc_o         = q.pc;
   assign mem_o        = q.mem;

endmodule

// File: verif/cfa_core_properties.sv
/* Port timing checker of the flag/ALU core.
   Assumes one clock and a synchronous active-low reset. */
`include "cfa_cfg.svh"

module cfa_core_properties #(
   parameter int unsigned OSC_DLY_CYC = 4096,
   parameter logic [7:0]  TRP_CODE    = 8'h00
) (
   // Clock and reset
   input wire logic                 mclk_i,
   input wire logic                 nrst_i,
   // Core inputs
   input wire cfa_pkg::cfa_bus_s    bus_i,
   input wire cfa_pkg::cfa_instr_s  instr_i,
   input wire cfa_pkg::cfa_sys_e    sys_cmd_i,
   input wire logic                 break_req_i,
   input wire logic                 irq_i,
   input wire logic                 ext_irq_i,
   // Core outputs
   input wire logic [7:0]           rd_data_o,
   input wire logic                 ready_o,
   input wire logic                 cpu_clk_en_o,
   input wire logic                 in_break_o,
   input wire logic [7:0]           ir_o,
   input wire logic [15:0]          pc_o,
   input wire cfa_pkg::cfa_mem_s    mem_o
);
   logic       take;
   logic       idle;
   logic [7:0] opnd_q;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   // Offers the core accepts
   assign idle = ready_o && !break_req_i;
   assign take = idle && instr_i.valid && sys_cmd_i == cfa_pkg::S_NONE;
   // Operand of the last offer
   always_ff @(posedge mclk_i)
      opnd_q <= instr_i.opnd;

   two_cyc_a: assert property (
      take && instr_i.op inside {16'h00AB, 16'h00A7, 16'h00AF}
      |=> !ready_o ##1 ready_o) else $error("two-cycle op timing");
   sp2_cyc_a: assert property (
      take && instr_i.op == 16'h9ED9 |=> !ready_o [*4] ##1 ready_o)
      else $error("stack offset add timing");
   shl_inh_a: assert property (
      take && instr_i.op == 16'h0048 |=> ready_o)
      else $error("inherent shift not one cycle");
   brc_cyc_a: assert property (
      take && instr_i.op == 16'h0024 |=> !ready_o [*2] ##1 ready_o)
      else $error("branch timing");
   shl_mem_a: assert property (
      take && instr_i.op == 16'h0038
      |=> mem_o.valid && mem_o.data == {opnd_q[6:0], 1'b0})
      else $error("memory shift left result");
   shr_mem_a: assert property (
      take && instr_i.op == 16'h0037
      |=> mem_o.valid && mem_o.data == {opnd_q[7], opnd_q[7:1]})
      else $error("memory shift right result");
   wait_gate_a: assert property (
      idle && sys_cmd_i == cfa_pkg::S_WAIT |=> !cpu_clk_en_o && !ready_o)
      else $error("wait did not gate clock");
   stop_gate_a: assert property (
      idle && sys_cmd_i == cfa_pkg::S_STOP |=> !cpu_clk_en_o && !ready_o)
      else $error("stop did not gate clock");
   brk_entry_a: assert property (
      ready_o && break_req_i && !in_break_o |=> in_break_o &&
      ir_o == TRP_CODE && pc_o inside {`CFA_VEC_BRK, `CFA_VEC_MON})
      else $error("break entry wrong");
   ret_end_a: assert property (
      idle && in_break_o && sys_cmd_i == cfa_pkg::S_RET |=> !in_break_o)
      else $error("return did not end break");
   ret_hold_a: assert property (
      in_break_o && break_req_i |=> in_break_o)
      else $error("break left while requested");
endmodule

bind cfa_core cfa_core_properties #(
   .OSC_DLY_CYC (OSC_DLY_CYC),
   .TRP_CODE    (TRP_CODE)
) chk (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus_i), .instr_i(instr_i),
   .sys_cmd_i(sys_cmd_i), .break_req_i(break_req_i), .irq_i(irq_i),
   .ext_irq_i(ext_irq_i), .rd_data_o(rd_data_o), .ready_o(ready_o),
   .cpu_clk_en_o(cpu_clk_en_o), .in_break_o(in_break_o), .ir_o(ir_o),
   .pc_o(pc_o), .mem_o(mem_o)
);

// File: verif/cfa_core_bench.sv
/* Self-checking bench of the flag/ALU core.
   Assumes the core alone, driven at its ports at 200 MHz. */
`include "cfa_cfg.svh"

module cfa_core_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned OSC = 4;
   localparam logic [7:0]  TRP = 8'h5A; // Arbitrary marker value
   // Stimulus
   logic                mclk_i      = 1'b0;
   logic                nrst_i      = 1'b0;
   cfa_pkg::cfa_bus_s   bus_i       = '0;
   cfa_pkg::cfa_instr_s instr_i     = '0;
   cfa_pkg::cfa_sys_e   sys_cmd_i   = cfa_pkg::S_NONE;
   logic                break_req_i = 1'b0;
   logic                irq_i       = 1'b0;
   logic                ext_irq_i   = 1'b0;
   // Observed outputs and counters
   logic [7:0]          rd_data_o;
   logic                ready_o;
   logic                cpu_clk_en_o;
   logic                in_break_o;
   logic [7:0]          ir_o;
   logic [15:0]         pc_o;
   cfa_pkg::cfa_mem_s   mem_o;
   int                  n_mismatch  = 0;
   int                  n_checks    = 0;
   int                  cyc         = 0;
   int                  n;

   cfa_core #(
      .OSC_DLY_CYC (OSC),
      .TRP_CODE    (TRP)
   ) uut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
      .instr_i(instr_i), .sys_cmd_i(sys_cmd_i), .ready_o(ready_o),
      .break_req_i(break_req_i), .irq_i(irq_i), .ext_irq_i(ext_irq_i),
      .cpu_clk_en_o(cpu_clk_en_o), .in_break_o(in_break_o), .ir_o(ir_o),
      .pc_o(pc_o), .mem_o(mem_o)
   );

   // Clock
   always #2.5 mclk_i = ~mclk_i;

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rst();
      @(posedge mclk_i) nrst_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      nrst_i <= 1'b1;
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i) bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i) bus_i.wr <= 1'b0;
      #1;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_i) bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i) bus_i.rd <= 1'b0;
      #1 cmp({8'h00, rd_data_o}, {8'h00, e});
   endtask

   task automatic exec(input logic [15:0] op, input logic [7:0] m);
      for (n = 0; n < 20 && ready_o !== 1'b1; n++)
         @(posedge mclk_i) #1;
      @(posedge mclk_i) instr_i <= '{valid: 1'b1, op: op, opnd: m};
      @(posedge mclk_i) instr_i.valid <= 1'b0;
      #1;
   endtask

   task automatic sys(input cfa_pkg::cfa_sys_e c);
      @(posedge mclk_i) sys_cmd_i <= c;
      @(posedge mclk_i) sys_cmd_i <= cfa_pkg::S_NONE;
      #1;
   endtask

   // Expected condition codes and accumulator
   function automatic logic [15:0] model(input logic [15:0] op,
                                         input logic [7:0] a, m, cc);
      logic [8:0] s;
      logic [4:0] hs;
      logic [7:0] r;
      logic [7:0] o;
      logic       ci;
      o  = cc;
      ci = cc[0] & (op[3:0] == 4'h9);
      s  = a + m + ci;
      hs = a[3:0] + m[3:0] + ci;
      case (op[3:0])
         4'h9, 4'hB:
         begin
            r    = s[7:0];
            o[7] = (a[7] == m[7]) && (r[7] != a[7]);
            o[4] = hs[4];
            o[0] = s[8];
         end
         4'h4:
         begin
            r    = a & m;
            o[7] = 1'b0;
         end
         4'h8:
         begin
            r    = {a[6:0], 1'b0};
            o[0] = a[7];
            o[7] = r[7] ^ a[7];
         end
         default:
         begin
            r    = {a[7], a[7:1]};
            o[0] = a[0];
            o[7] = r[7] ^ a[0];
         end
      endcase
      o[2] = r[7];
      o[1] = (r == 8'h00);
      return {o, r};
   endfunction

   task automatic alu(input logic [15:0] op, input logic [7:0] a, m, cc);
      logic [15:0] e;
      e = model(op, a, m, cc);
      wr(`CFA_OFF_ACC, a);
      wr(`CFA_OFF_CND, cc);
      exec(op, m);
      rdc(`CFA_OFF_ACC, e[7:0]);
      rdc(`CFA_OFF_CND, e[15:8]);
   endtask

   // Main sequence
   initial
   begin
      rst();
      rdc(`CFA_OFF_CND, 8'h68);
      rdc(`CFA_OFF_SP_LO, 8'hFF);
      rdc(4'hF, 8'h00);
      cmp(pc_o, 16'hFFFE);
      exec(16'h0024, 8'h10);
      cmp(pc_o, 16'h0010);
      wr(`CFA_OFF_CND, 8'h69);
      exec(16'h0024, 8'h10);
      cmp(pc_o, 16'h0012);
      alu(16'h00A9, 8'h78, 8'h07, 8'h69);
      alu(16'h00AB, 8'h80, 8'h80, 8'h69);
      alu(16'h9ED9, 8'hFF, 8'h00, 8'h69);
      alu(16'h00A4, 8'hF0, 8'h3C, 8'hF9);
      alu(16'h0048, 8'hC1, 8'h00, 8'h68);
      alu(16'h0047, 8'h81, 8'h00, 8'h68);
      alu(16'h0047, 8'h01, 8'h00, 8'h68);
      exec(16'h0038, 8'h81);
      cmp({7'h00, mem_o.valid, mem_o.data}, 16'h0102);
      exec(16'h0037, 8'h81);
      cmp({7'h00, mem_o.valid, mem_o.data}, 16'h01C0);
      // Signed immediate adds leave flags alone
      wr(`CFA_OFF_CND, 8'h6B);
      exec(16'h00A7, 8'h80);
      rdc(`CFA_OFF_SP_HI, 8'h00);
      rdc(`CFA_OFF_SP_LO, 8'h7F);
      wr(`CFA_OFF_HX_HI, 8'h12);
      wr(`CFA_OFF_HX_LO, 8'h34);
      exec(16'h00AF, 8'hFE);
      rdc(`CFA_OFF_HX_HI, 8'h12);
      rdc(`CFA_OFF_HX_LO, 8'h32);
      rdc(`CFA_OFF_CND, 8'h6B);
      // Wait with interrupt wake
      wr(`CFA_OFF_CND, 8'h68);
      sys(cfa_pkg::S_WAIT);
      cmp(cpu_clk_en_o, 1'b0);
      rdc(`CFA_OFF_CND, 8'h60);
      @(posedge mclk_i) irq_i <= 1'b1;
      @(posedge mclk_i) irq_i <= 1'b0;
      #1 cmp(cpu_clk_en_o, 1'b1);
      rdc(`CFA_OFF_CND, 8'h60);
      // Stop with external wake and oscillator delay
      wr(`CFA_OFF_CND, 8'h68);
      sys(cfa_pkg::S_STOP);
      cmp(cpu_clk_en_o, 1'b0);
      @(posedge mclk_i) ext_irq_i <= 1'b1;
      for (n = 0; n < 40 && cpu_clk_en_o !== 1'b1; n++)
         @(posedge mclk_i) #1;
      @(posedge mclk_i) ext_irq_i <= 1'b0;
      cmp(n > OSC && n < OSC + 8, 1'b1);
      rdc(`CFA_OFF_CND, 8'h60);
      // Wait left by reset
      sys(cfa_pkg::S_WAIT);
      rst();
      rdc(`CFA_OFF_CND, 8'h68);
      // Break while idle, return refused then accepted
      @(posedge mclk_i) break_req_i <= 1'b1;
      @(posedge mclk_i) #1;
      cmp(in_break_o, 1'b1);
      cmp(ir_o, TRP);
      cmp(pc_o, `CFA_VEC_BRK);
      sys(cfa_pkg::S_RET);
      cmp(in_break_o, 1'b1);
      @(posedge mclk_i) break_req_i <= 1'b0;
      sys(cfa_pkg::S_RET);
      cmp(in_break_o, 1'b0);
      // Break during a long instruction in monitor mode
      wr(`CFA_OFF_CTRL, 8'h01);
      exec(16'h9ED9, 8'h00);
      @(posedge mclk_i) break_req_i <= 1'b1;
      @(posedge mclk_i) #1;
      cmp(in_break_o, 1'b0);
      for (n = 0; n < 10 && in_break_o !== 1'b1; n++)
         @(posedge mclk_i) #1;
      cmp(n < 4, 1'b1);
      cmp(pc_o, `CFA_VEC_MON);
      // Unknown code sets the sticky flag, a written one clears it
      exec(16'h0001, 8'h00);
      rdc(`CFA_OFF_STAT, 8'h07);
      wr(`CFA_OFF_STAT, 8'h01);
      rdc(`CFA_OFF_STAT, 8'h06);
      rdc(`CFA_OFF_CTRL, 8'h01);
      final_report();
   end
endmodule
